// ===== core/afe_pin_if.sv
`timescale 1ns/1ns

// ****************************************************************
// Read data buffer
// ****************************************************************
module afe_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             arst_n,
  input  wire logic             flush,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int unsigned PW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : gDepthCheck
    $error("afe_fifo depth must be a power of two of at least two.");
  end

  typedef struct packed {
    logic [PW-1:0] wrPtr;
    logic [PW-1:0] rdPtr;
    logic [PW:0]   count;
    logic          full;
    logic          empty;
  } afeFifoState_t;

  afeFifoState_t    state_r;
  afeFifoState_t    state_nxt;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             doPush;
  logic             doPop;

  assign inReady  = ~state_r.full;
  assign outValid = ~state_r.empty;
  assign outData  = mem[state_r.rdPtr];

  // Pointers and flags advance together so full and empty never disagree with the count.
  always_comb begin
    state_nxt = state_r;
    doPush    = inValid & ~state_r.full;
    doPop     = outReady & ~state_r.empty;
    if (doPush) begin
      state_nxt.wrPtr = state_r.wrPtr + 1'b1;
    end
    if (doPop) begin
      state_nxt.rdPtr = state_r.rdPtr + 1'b1;
    end
    state_nxt.count = state_r.count + {{PW{1'b0}}, doPush} - {{PW{1'b0}}, doPop};
    if (flush) begin
      state_nxt = '0;
    end
    state_nxt.full  = (state_nxt.count == (PW+1)'(DEPTH));
    state_nxt.empty = (state_nxt.count == '0);
  end

  // Storage has no reset; only the pointers decide what is valid.
  always_ff @(posedge clk_sys) begin
    if (doPush) begin
      mem[state_r.wrPtr] <= inData;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_r       <= '0;
      state_r.empty <= 1'b1;
    end else begin
      state_r <= state_nxt;
    end
  end
endmodule

// ****************************************************************
// Pin level interface of the converter front end
// ****************************************************************
// How it works
// - In SPI mode the idle ready pin is driven high when drive select is one, else floats; two-wire mode always floats it.
// - Each conversion end gives one fixed-width low pulse timed by the master clock.
// - Low pulse lasts half a digital clock period, repeating at the data rate.
// - Ready pulses ignore serial activity and depend only on clock, prescale, ratio.
// - Two-wire entry, or watchdog reset with two-wire selected, latches ready, oscillator, select, data-in and reset pin straps.
// - External clock select turns the crystal off and uses the input pin directly.
// - With external clock, oscillator output pin selects SPI when low, two-wire when high.
// - Mode pin is caught after power-on, master reset and watchdog reset only.
// - Frames open on select falling, close on select rising; idle select ignores all.
// - No serial traffic is accepted while the reset pin is low.
// - Data in is taken on serial clock rises, data out changes on falls.
// - Serial modes 0,0 and 1,1 work; host changes mode only with select high.
// - Serial clock up to 20 MHz is unrelated to the master clock; here it must be synchronous and well under a quarter of that clock.
// - Data out floats during command, writes, idle select and reset; driven for reads.
// - Input and output phases of a frame never overlap.
// - Data-in toggles after the command or with select high have no effect.
// - Reset pin low restores defaults, blocks traffic and halts the clock tree.
// - Prescale codes 0 to 3 divide the master clock by 1, 2, 4, 8.
// - Digital clock is analog clock over four, one modulator sample per period.
// - Data rate equals digital clock over the oversampling ratio.
module afe_pin_if #(
  parameter int unsigned DATA_W     = 8,
  parameter int unsigned FIFO_DEPTH = 8
) (
  input  wire logic                clk_sys,
  input  wire logic                arst_n,
  input  wire logic                resetPinN,
  input  wire afe_pkg::afeSpiIn_t  spiIn,
  output afe_pkg::afeSpiOut_t      spiOut,
  input  wire logic                readyPinIn,
  output logic                     readyPinOut,
  output logic                     readyPinOe,
  input  wire logic                oscInPin,
  input  wire logic                oscOutPin,
  input  wire logic                watchdogReset,
  input  wire logic                readyOutputDriveSelect,
  input  wire logic                externalClockSelect,
  input  wire logic [1:0]          prescaleSelect,
  input  wire logic [2:0]          osrSelect,
  output logic                     oscillatorEnable,
  output afe_pkg::afeMode_t        interfaceMode,
  output afe_pkg::afeStraps_t      straps,
  output logic                     cmdValid,
  output logic [DATA_W-1:0]        cmdByte,
  input  wire logic                readDataValid,
  output logic                     readDataReady,
  input  wire logic [DATA_W-1:0]   readData
);
  if (DATA_W != afe_pkg::CMD_BITS) begin : gWidthCheck
    $error("afe_pin_if byte width must match the command width.");
  end

  typedef struct packed {
    logic                porDone;
    logic                resetPinPrev;
    logic                sckPrev;
    logic                csPrev;
    afe_pkg::afePhase_t  phase;
    logic [2:0]          inCnt;
    logic [2:0]          outCnt;
    logic [DATA_W-1:0]   shiftIn;
    logic [DATA_W-1:0]   shiftOut;
    logic                cmdValid;
    logic [DATA_W-1:0]   cmdByte;
    afe_pkg::afeSpiOut_t spiOut;
    afe_pkg::afeMode_t   mode;
    afe_pkg::afeStraps_t straps;
    logic                oscEnable;
    logic [4:0]          divCnt;
    logic [11:0]         osrCnt;
    logic [3:0]          pulseCnt;
    logic                readyLow;
    logic                readyOut;
    logic                readyOe;
  } afePinState_t;

  afePinState_t      state_r;
  afePinState_t      state_nxt;
  logic              fifoValid;
  logic [DATA_W-1:0] fifoData;
  logic              fifoPop;
  logic              fifoFlush;
  logic              fifoInReady;
  logic [4:0]        dmLimit;
  logic [11:0]       osrLimit;
  logic [3:0]        halfLimit;
  logic              sckRise;
  logic              sckFall;
  logic              csFall;
  logic              spiLive;
  logic              capture;
  afe_pkg::afeMode_t newMode;
  logic [DATA_W-1:0] nextByte;

  // Bytes wait here until a read frame shifts them out, so software may run ahead.
  afe_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) uReadFifo (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .flush    (fifoFlush),
    .inValid  (readDataValid),
    .inReady  (fifoInReady),
    .inData   (readData),
    .outValid (fifoValid),
    .outReady (fifoPop),
    .outData  (fifoData)
  );

  // Division limits follow the prescale and ratio codes as shifts of one.
  assign dmLimit   = 5'((1 << (afe_pkg::DIGITAL_MASTER_CLOCK_SHIFT + prescaleSelect)) - 1);
  assign osrLimit  = 12'((1 << (afe_pkg::OSR_MIN_SHIFT + osrSelect)) - 1);
  assign halfLimit = 4'((1 << (afe_pkg::HALF_DM_SHIFT + prescaleSelect)) - 1);

  // Serial pins are already in this clock's timing, so edges come from one-cycle history.
  // The serial clock must be well under a quarter of the system clock for this to hold.
  assign sckRise = spiIn.sck & ~state_r.sckPrev;
  assign sckFall = ~spiIn.sck & state_r.sckPrev;
  assign csFall  = ~spiIn.csN & state_r.csPrev;
  assign spiLive = resetPinN & (state_r.mode == afe_pkg::AFE_MODE_SPI);

  // Mode is re-read only on power-on, master reset release and watchdog reset.
  assign capture = ~state_r.porDone | (resetPinN & ~state_r.resetPinPrev) | watchdogReset;
  assign newMode = (externalClockSelect && oscOutPin) ? afe_pkg::AFE_MODE_TWO_WIRE
                                                      : afe_pkg::AFE_MODE_SPI;
  assign nextByte = fifoValid ? fifoData : '0;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    state_nxt              = state_r;
    fifoPop                = 1'b0;
    fifoFlush              = 1'b0;
    state_nxt.porDone      = 1'b1;
    state_nxt.resetPinPrev = resetPinN;
    state_nxt.sckPrev      = spiIn.sck;
    state_nxt.csPrev       = spiIn.csN;
    state_nxt.cmdValid     = 1'b0;
    state_nxt.oscEnable    = ~externalClockSelect;

    // Mode and strap latching; straps follow entry into two-wire mode or a watchdog reset that selects two-wire mode.
    if (capture) begin
      state_nxt.mode = newMode;
      if (newMode == afe_pkg::AFE_MODE_TWO_WIRE &&
          (state_r.mode != afe_pkg::AFE_MODE_TWO_WIRE || watchdogReset)) begin
        state_nxt.straps.gain_strap_bit1 = readyPinIn;
        state_nxt.straps.gain_strap_bit0 = oscInPin;
        state_nxt.straps.boost = spiIn.csN;
        state_nxt.straps.oversampling_strap_bit1  = spiIn.sdi;
        state_nxt.straps.osr0  = resetPinN;
      end
    end

    // Frame sequencing; a frame in flight is dropped whenever select rises.
    if (!spiLive || spiIn.csN == afe_pkg::CS_IDLE_LEVEL) begin
      state_nxt.phase        = afe_pkg::AFE_PH_IDLE;
      state_nxt.spiOut.sdoOe = 1'b0;
      state_nxt.spiOut.sdo   = 1'b0;
    end else if (csFall) begin
      state_nxt.phase  = afe_pkg::AFE_PH_CMD;
      state_nxt.inCnt  = '0;
      state_nxt.outCnt = '0;
    end else begin
      unique case (state_r.phase)
        afe_pkg::AFE_PH_CMD: begin
          // Falling edges in the command phase are ignored, which serves mode 1,1 too.
          if (sckRise) begin
            state_nxt.shiftIn = {state_r.shiftIn[DATA_W-2:0], spiIn.sdi};
            state_nxt.inCnt   = state_r.inCnt + 3'h1;
            if (state_r.inCnt == afe_pkg::CMD_LAST_BIT) begin
              state_nxt.cmdValid = 1'b1;
              state_nxt.cmdByte  = {state_r.shiftIn[DATA_W-2:0], spiIn.sdi};
              state_nxt.phase    = spiIn.sdi ? afe_pkg::AFE_PH_READ
                                             : afe_pkg::AFE_PH_WRITE;
            end
          end
        end
        afe_pkg::AFE_PH_READ: begin
          // Output starts only after the command is in, so directions never overlap.
          if (sckFall) begin
            state_nxt.spiOut.sdoOe = 1'b1;
            state_nxt.outCnt       = state_r.outCnt + 3'h1;
            if (state_r.outCnt == '0) begin
              fifoPop              = fifoValid;
              state_nxt.spiOut.sdo = nextByte[DATA_W-1];
              state_nxt.shiftOut   = {nextByte[DATA_W-2:0], 1'b0};
            end else begin
              state_nxt.spiOut.sdo = state_r.shiftOut[DATA_W-1];
              state_nxt.shiftOut   = {state_r.shiftOut[DATA_W-2:0], 1'b0};
            end
          end
        end
        afe_pkg::AFE_PH_WRITE: begin
          state_nxt.spiOut.sdoOe = 1'b0;
        end
        afe_pkg::AFE_PH_IDLE: begin
          state_nxt.spiOut.sdoOe = 1'b0;
        end
      endcase
    end

    // Conversion timing runs free of the serial side.
    state_nxt.divCnt = (state_r.divCnt >= dmLimit) ? '0 : state_r.divCnt + 5'h1;
    if (state_r.divCnt >= dmLimit) begin
      state_nxt.osrCnt = (state_r.osrCnt >= osrLimit) ? '0 : state_r.osrCnt + 12'h1;
      if (state_r.osrCnt >= osrLimit) begin
        state_nxt.readyLow = 1'b1;
        state_nxt.pulseCnt = '0;
      end
    end
    if (state_r.readyLow) begin
      state_nxt.pulseCnt = state_r.pulseCnt + 4'h1;
      if (state_r.pulseCnt >= halfLimit) begin
        state_nxt.readyLow = 1'b0;
      end
    end

    // Master reset idles the frame, clears data out, conversion counters and the ready pulse, and flushes the buffer.
    if (!resetPinN) begin
      state_nxt.phase    = afe_pkg::AFE_PH_IDLE;
      state_nxt.spiOut   = '0;
      state_nxt.divCnt   = '0;
      state_nxt.osrCnt   = '0;
      state_nxt.pulseCnt = '0;
      state_nxt.readyLow = 1'b0;
      fifoFlush          = 1'b1;
    end

    // In SPI mode a low pulse is always driven, otherwise the select decides drive or float; two-wire mode floats the pin.
    state_nxt.readyOut = ~state_nxt.readyLow;
    state_nxt.readyOe  = (state_nxt.mode == afe_pkg::AFE_MODE_SPI) &&
                         (state_nxt.readyLow || readyOutputDriveSelect);
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_r              <= '0;
      state_r.resetPinPrev <= 1'b1;
      state_r.sckPrev      <= 1'b0;
      state_r.csPrev       <= afe_pkg::CS_IDLE_LEVEL;
      state_r.phase        <= afe_pkg::AFE_PH_IDLE;
      state_r.mode         <= afe_pkg::AFE_MODE_SPI;
      state_r.oscEnable    <= ~afe_pkg::EXT_CLK_RESET;
      state_r.readyOut     <= 1'b1;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Outputs come straight from the state register or the buffer's flag flop.
  assign spiOut           = state_r.spiOut;
  assign readyPinOut      = state_r.readyOut;
  assign readyPinOe       = state_r.readyOe;
  assign oscillatorEnable = state_r.oscEnable;
  assign interfaceMode    = state_r.mode;
  assign straps           = state_r.straps;
  assign cmdValid         = state_r.cmdValid;
  assign cmdByte          = state_r.cmdByte;
  assign readDataReady    = fifoInReady;
endmodule

// ===== shared/afe_pkg.sv
package afe_pkg;

  // ****************************************************************
  // Serial framing
  // ****************************************************************
  localparam int unsigned CMD_BITS      = 8;
  localparam logic [2:0]  CMD_LAST_BIT  = 3'h7;
  localparam int unsigned CMD_RW_POS    = 0;     // Command bit that marks a read when set.
  localparam logic        CS_IDLE_LEVEL = 1'h1;
  localparam int unsigned SCK_MAX_MHZ   = 20;
  localparam int unsigned CLK_SYS_MHZ   = 100;

  // ****************************************************************
  // Clock tree division
  // ****************************************************************
  localparam int unsigned DIGITAL_MASTER_CLOCK_SHIFT    = 2;     // Digital clock is analog clock over four.
  localparam int unsigned HALF_DM_SHIFT  = 1;     // Half a digital clock period.
  localparam int unsigned OSR_MIN_SHIFT  = 5;     // Smallest oversampling ratio is 32.
  localparam logic [1:0]  PRESCALE_RESET = 2'h0;
  localparam logic        DRIVE_SEL_RESET = 1'h0;
  localparam logic        EXT_CLK_RESET   = 1'h1;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic {
    AFE_MODE_SPI,
    AFE_MODE_TWO_WIRE
  } afeMode_t;

  typedef enum logic [1:0] {
    AFE_PH_IDLE,
    AFE_PH_CMD,
    AFE_PH_READ,
    AFE_PH_WRITE
  } afePhase_t;

  typedef struct packed {
    logic gain_strap_bit1;
    logic gain_strap_bit0;
    logic boost;
    logic oversampling_strap_bit1;
    logic osr0;
  } afeStraps_t;

  typedef struct packed {
    logic       csN;
    logic       sck;
    logic       sdi;
  } afeSpiIn_t;

  typedef struct packed {
    logic       sdo;
    logic       sdoOe;
  } afeSpiOut_t;

endpackage

// ===== test/afe_pin_if_monitor.sv
`timescale 1ns/1ns

// ****************************************************************
// Port checks of the converter pin interface
// ****************************************************************
module afe_pin_if_monitor #(
  parameter int unsigned DATA_W = 8
) (
  input wire logic                clk_sys,
  input wire logic                arst_n,
  input wire logic                resetPinN,
  input wire afe_pkg::afeSpiIn_t  spiIn,
  input wire afe_pkg::afeSpiOut_t spiOut,
  input wire logic                readyPinOut,
  input wire logic                readyPinOe,
  input wire logic                oscOutPin,
  input wire logic                watchdogReset,
  input wire logic                readyOutputDriveSelect,
  input wire logic                externalClockSelect,
  input wire logic [1:0]          prescaleSelect,
  input wire logic                oscillatorEnable,
  input wire afe_pkg::afeMode_t   interfaceMode,
  input wire logic                cmdValid,
  input wire logic [DATA_W-1:0]   cmdByte
);
  // Everything runs on the system clock and rests during power-on reset.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  // Data out, command, ready, oscillator and mode checks.
  chk_sdo_select_idle: assert property (spiIn.csN |=> !spiOut.sdoOe)
    else $error("data out driven while select is high");
  chk_sdo_cmd_float: assert property ($fell(spiIn.csN) |-> !spiOut.sdoOe [*8])
    else $error("data out driven during the command");
  chk_write_float: assert property (
    cmdValid && !cmdByte[afe_pkg::CMD_RW_POS] |-> !spiOut.sdoOe [*8])
    else $error("data out driven in a write frame");
  chk_reset_no_cmd: assert property (!resetPinN [*2] |=> !cmdValid)
    else $error("command accepted with the reset pin low");
  chk_ready_width: assert property (disable iff (!arst_n || !resetPinN)
    $fell(readyPinOut) && prescaleSelect == 2'h0 |-> !readyPinOut [*2] ##1 readyPinOut)
    else $error("ready pulse width wrong");
  chk_ready_float: assert property (
    !readyOutputDriveSelect && !$past(readyOutputDriveSelect) && readyPinOut |-> !readyPinOe)
    else $error("idle ready pin driven with drive select low");
  chk_osc_follow: assert property (
    $past(arst_n) |-> oscillatorEnable == !$past(externalClockSelect))
    else $error("oscillator enable does not follow clock select");
  chk_mode_forced: assert property (
    !externalClockSelect && resetPinN && !$past(resetPinN)
    |=> interfaceMode == afe_pkg::AFE_MODE_SPI)
    else $error("mode not serial with the crystal in use");
  chk_mode_hold: assert property (
    $changed(oscOutPin) && resetPinN && $past(resetPinN) && $past(resetPinN, 2)
    && $past(arst_n) && !watchdogReset && !$past(watchdogReset) && externalClockSelect
    |=> $stable(interfaceMode))
    else $error("mode changed without a reset event");
endmodule

bind afe_pin_if afe_pin_if_monitor #(.DATA_W(DATA_W)) u_mon (
  .clk_sys, .arst_n, .resetPinN, .spiIn, .spiOut, .readyPinOut, .readyPinOe,
  .oscOutPin, .watchdogReset, .readyOutputDriveSelect, .externalClockSelect,
  .prescaleSelect, .oscillatorEnable, .interfaceMode, .cmdValid, .cmdByte
);

// ===== test/afe_host_model.sv
`timescale 1ns/1ns

// ****************************************************************
// Serial host model, clock idle low
// ****************************************************************
module afe_host_model (
  input  wire logic                clk_sys,
  output afe_pkg::afeSpiIn_t       spiIn,
  input  wire afe_pkg::afeSpiOut_t spiOut
);
  logic sawDrive;

  // Select starts high with the clock low, so nothing is framed.
  initial begin
    spiIn = '{csN: 1'b1, sck: 1'b0, sdi: 1'b0};
    sawDrive = 1'b0;
  end

  // Remembers any driven data out inside a frame.
  always @(posedge clk_sys) begin
    if (!spiIn.csN && spiOut.sdoOe === 1'b1) begin
      sawDrive <= 1'b1;
    end
  end

  // Five system clocks per half period; the design cannot sample a 20 MHz clock.
  task automatic half();
    repeat (5) @(negedge clk_sys);
  endtask

  // Command first, then nRd bytes; the last rise is not followed by a fall,
  // because a fall would pop a byte that the frame then throws away.
  task automatic frame(input logic [7:0] cmd, input int nRd, output logic [15:0] rd);
    sawDrive = 1'b0;
    rd = 16'h0000;
    spiIn.csN = 1'b0;
    half();
    for (int i = 0; i < 8 * (nRd + 1); i++) begin
      spiIn.sdi = (i < 8) ? cmd[7 - i] : ~spiIn.sdi;
      half();
      spiIn.sck = 1'b1;
      if (i >= 8) begin
        rd = {rd[14:0], spiOut.sdo};
      end
      half();
      if (i < 8 * nRd + 7) begin
        spiIn.sck = 1'b0;
      end
    end
    spiIn.csN = 1'b1;
    half();
    spiIn.sck = 1'b0;
    spiIn.sdi = ~spiIn.sdi;
    half();
  endtask
endmodule

// ===== test/afe_pin_if_tb.sv
`timescale 1ns/1ns

// ****************************************************************
// Bench for the converter pin interface
// ****************************************************************
module afe_pin_if_tb;
  logic                clk_sys = 1'b0;
  logic                arst_n = 1'b0;
  logic                resetPinN = 1'b1;
  logic                gainDrive = 1'b1;
  logic                oscInPin = 1'b0;
  logic                oscOutPin = 1'b0;
  logic                watchdogReset = 1'b0;
  logic                drvSel = 1'b0;
  logic                extClk = 1'b1;
  logic [1:0]          pre = 2'h0;
  logic [2:0]          osr = 3'h0;
  logic                readDataValid = 1'b0;
  logic [7:0]          readData = 8'h00;
  afe_pkg::afeSpiIn_t  spiIn;
  afe_pkg::afeSpiOut_t spiOut;
  afe_pkg::afeMode_t   mode;
  afe_pkg::afeStraps_t straps;
  logic                readyPinOut, readyPinOe, oscEn, cmdValid, readDataReady;
  logic [7:0]          cmdByte, lastCmd;
  logic [15:0]         rd;
  int                  n_mismatch = 0, num_checks = 0, nCmd = 0, n, lowW, per;
  // The ready pin has no pull-up; off the design's drive it shows the strap level gainDrive.
  wire                 readyPinIn = readyPinOe ? readyPinOut : gainDrive;

  afe_host_model host (.clk_sys, .spiIn, .spiOut);
  afe_pin_if dut (
    .clk_sys, .arst_n, .resetPinN, .spiIn, .spiOut, .readyPinIn, .readyPinOut,
    .readyPinOe, .oscInPin, .oscOutPin, .watchdogReset, .readyOutputDriveSelect(drvSel),
    .externalClockSelect(extClk), .prescaleSelect(pre), .osrSelect(osr),
    .oscillatorEnable(oscEn), .interfaceMode(mode), .straps, .cmdValid, .cmdByte,
    .readDataValid, .readDataReady, .readData
  );

  // One free-running clock also stands in for the continuous two-wire clock.
  always #5 clk_sys = ~clk_sys;

  // Command pulses stand one cycle, so they are counted at every rising edge.
  always @(posedge clk_sys) begin
    if (cmdValid === 1'b1) begin
      nCmd <= nCmd + 1;
      lastCmd <= cmdByte;
    end
  end

  function automatic logic [7:0] dat(input int i);
    return 8'h5a ^ 8'(i * 37);
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Low width and fall-to-fall period of the ready pulse, in clocks.
  task automatic measure();
    lowW = 0;
    while (readyPinOut !== 1'b0) @(negedge clk_sys);
    while (readyPinOut === 1'b0) begin
      lowW++;
      @(negedge clk_sys);
    end
    per = lowW;
    while (readyPinOut !== 1'b0) begin
      per++;
      @(negedge clk_sys);
    end
  endtask

  task automatic pinReset();
    resetPinN = 1'b0;
    repeat (2) @(negedge clk_sys);
    resetPinN = 1'b1;
    repeat (4) @(negedge clk_sys);
  endtask

  // Main sequence; every input changes on the falling edge.
  initial begin
    repeat (2) @(negedge clk_sys);
    check({spiOut.sdoOe, readyPinOe, readyPinOut, mode, cmdValid, readDataReady}, 6'h09);
    arst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    for (int k = 0; k < 2; k++) begin
      drvSel = k[0];
      pre = k[1:0];
      osr = k[2:0];
      measure();
      measure();
      check(16'(lowW), 16'(2 << k));
      check(16'(per), 16'((4 << k) * (32 << k)));
      repeat (20) @(negedge clk_sys);
      check({readyPinOe, readyPinOut}, {drvSel, 1'b1});
    end
    drvSel = 1'b0;
    pre = 2'h0;
    osr = 3'h0;
    // Fill the buffer until it refuses.
    readDataValid = 1'b1;
    for (n = 0; readDataReady === 1'b1 && n < 12; n++) begin
      readData = dat(n);
      @(negedge clk_sys);
    end
    readDataValid = 1'b0;
    check(16'(n), 16'h0008);
    host.frame(8'h41, 2, rd);
    check(rd, {dat(0), dat(1)});
    check({host.sawDrive, lastCmd}, {1'b1, 8'h41});
    host.frame(8'h41, 2, rd);
    check(rd, {dat(2), dat(3)});
    host.frame(8'h82, 1, rd);
    check({host.sawDrive, lastCmd}, {1'b0, 8'h82});
    check(16'(nCmd), 16'h0003);
    resetPinN = 1'b0;
    host.frame(8'h43, 1, rd);
    resetPinN = 1'b1;
    repeat (4) @(negedge clk_sys);
    check({host.sawDrive, 8'(nCmd)}, {1'b0, 8'h03});
    host.frame(8'h45, 1, rd);
    check(rd[7:0], 8'h00);
    // Straps and interface mode.
    oscOutPin = 1'b1;
    gainDrive = 1'b0;
    oscInPin = 1'b1;
    repeat (4) @(negedge clk_sys);
    check(mode, afe_pkg::AFE_MODE_SPI);
    watchdogReset = 1'b1;
    @(negedge clk_sys);
    watchdogReset = 1'b0;
    repeat (4) @(negedge clk_sys);
    check(mode, afe_pkg::AFE_MODE_TWO_WIRE);
    check(straps, {1'b0, 1'b1, spiIn.csN, spiIn.sdi, resetPinN});
    host.frame(8'h47, 1, rd);
    check({readyPinOe, 8'(nCmd)}, {1'b0, 8'h04});
    extClk = 1'b0;
    repeat (3) @(negedge clk_sys);
    check({oscEn, mode}, {1'b1, afe_pkg::AFE_MODE_TWO_WIRE});
    pinReset();
    check(mode, afe_pkg::AFE_MODE_SPI);
    extClk = 1'b1;
    pinReset();
    check(mode, afe_pkg::AFE_MODE_TWO_WIRE);
    oscOutPin = 1'b0;
    pinReset();
    check(mode, afe_pkg::AFE_MODE_SPI);
    report_and_stop();
  end

  // The sequence needs well under 100 microseconds.
  initial begin
    #300000;
    n_mismatch++;
    report_and_stop();
  end
endmodule
